// ==== shared/cb_window_pkg.sv ====
// Package: register map, field layout, reset values and types of the window decode block
package cb_window_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] LatencyOffset = 8'h1b;
    localparam logic [7:0] MemBase0Offset = 8'h1c;
    localparam logic [7:0] MemLimit0Offset = 8'h20;
    localparam logic [7:0] MemBase1Offset = 8'h24;
    localparam logic [7:0] MemLimit1Offset = 8'h28;
    localparam logic [7:0] IoBase0Offset = 8'h2c;
    localparam logic [7:0] IoLimit0Offset = 8'h30;
    localparam logic [7:0] IoBase1Offset = 8'h34;
    localparam logic [7:0] IoLimit1Offset = 8'h38;
    localparam logic [7:0] IrqLineOffset = 8'h3c;
    localparam logic [7:0] IrqPinOffset = 8'h3d;

    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int MemLowBits = 12;
    localparam int IoLowBits = 2;
    localparam int IoTopBit = 15;
    localparam logic [31:0] MemWriteMask = 32'hfffff000;
    localparam logic [31:0] IoWriteMask = 32'h0000fffc;
    localparam logic [31:0] MemLimitFill = 32'h00000fff;
    localparam logic [31:0] IoLimitFill = 32'h00000003;
    localparam int PrefetchBit0 = 8;
    localparam int PrefetchBit1 = 9;
    localparam int IoBaseSelBit = 11;
    localparam int IoLimitSelBit = 12;
    localparam int JoinAllBit = 28;
    localparam int JoinSecondBit = 29;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] LatencyReset = 8'h00;
    localparam logic [31:0] WindowReset = 32'h00000000;
    localparam logic [7:0] IrqLineReset = 8'hff;
    localparam logic [7:0] PinIntA = 8'h01;
    localparam logic [7:0] PinIntC = 8'h03;
    localparam logic [1:0] IoTypeSixteen = 2'h0;
    localparam logic [1:0] IoTypeThirtyTwo = 2'h1;
    localparam logic [1:0] PrefetchReset = 2'h3;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wdata;
    } cfg_req_type;

    typedef struct packed {
        logic isIo;
        logic [31:0] addr;
    } decode_req_type;

    typedef struct packed {
        logic hit;
        logic window1;
        logic prefetchable;
    } decode_rsp_type;

endpackage : cb_window_pkg

// ==== src/cardbus_window_decode_regs.sv ====
// Module: configuration registers, forwarding windows and latency timer of the card bridge
`timescale 1ns/1ns
module cardbus_window_decode_regs #(
    parameter int LatencyWidth = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire cb_window_pkg::cfg_req_type cfgReq,
    output logic [31:0] cfgRdata,
    output logic cfgRvalid,
    input wire logic window0Prefetchable,
    input wire logic window1Prefetchable,
    input wire logic [15:0] generalControl,
    input wire logic [31:0] systemControl,
    input wire cb_window_pkg::decode_req_type hostReq,
    output cb_window_pkg::decode_rsp_type hostRsp,
    input wire cb_window_pkg::decode_req_type cardReq,
    output cb_window_pkg::decode_rsp_type cardRsp,
    input wire logic cclkPin,
    input wire logic frameStart,
    input wire logic dataPhaseDone,
    input wire logic transactionActive,
    output logic latencyExpired,
    output logic terminateAfterPhase,
    input wire logic [3:0] intIn,
    output logic [3:0] intOut,
    output logic [7:0] secondFuncPin
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [LatencyWidth-1:0] latency_q;
    logic [31:12] memBase_q [2];
    logic [31:12] memLimit_q [2];
    logic [15:2] ioBase_q [2];
    logic [15:2] ioLimit_q [2];
    logic [7:0] irqLine_q;

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    wire logic [7:0] wordAddr = {cfgReq.addr[7:2], 2'h0};
    // Latency byte shares its word with the bus number bytes below it
    wire logic [7:0] latencyWordAddr = {cb_window_pkg::LatencyOffset[7:2], 2'h0};
    wire logic wrEn = cfgReq.wr;
    wire logic wrLatencyWord = wrEn && (wordAddr == latencyWordAddr) && cfgReq.byteEn[3];
    wire logic wrIrqWord = wrEn && (wordAddr == cb_window_pkg::IrqLineOffset)
        && cfgReq.byteEn[0];
    wire logic [31:0] byteMask = {{8{cfgReq.byteEn[3]}}, {8{cfgReq.byteEn[2]}},
        {8{cfgReq.byteEn[1]}}, {8{cfgReq.byteEn[0]}}};
    wire logic [31:0] wrData = cfgReq.wdata & byteMask;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            latency_q <= LatencyWidth'(cb_window_pkg::LatencyReset);
            irqLine_q <= cb_window_pkg::IrqLineReset;
        end
        else
        begin
            if (wrLatencyWord)
                latency_q <= LatencyWidth'(cfgReq.wdata[31:24]);
            if (wrIrqWord)
                irqLine_q <= cfgReq.wdata[7:0];
        end
    end

    // ----------------------------------------
    // Window registers, per window
    // ----------------------------------------
    for (genvar w = 0; w < 2; w++)
    begin : gWin
        localparam logic [7:0] MemBaseOff = (w == 0) ? cb_window_pkg::MemBase0Offset
            : cb_window_pkg::MemBase1Offset;
        localparam logic [7:0] MemLimitOff = (w == 0) ? cb_window_pkg::MemLimit0Offset
            : cb_window_pkg::MemLimit1Offset;
        localparam logic [7:0] IoBaseOff = (w == 0) ? cb_window_pkg::IoBase0Offset
            : cb_window_pkg::IoBase1Offset;
        localparam logic [7:0] IoLimitOff = (w == 0) ? cb_window_pkg::IoLimit0Offset
            : cb_window_pkg::IoLimit1Offset;
        // Disabled byte lanes keep their old contents
        wire logic [31:0] mbMasked = wrData | ({memBase_q[w], 12'h0} & ~byteMask);
        wire logic [31:0] mlMasked = wrData | ({memLimit_q[w], 12'h0} & ~byteMask);
        wire logic [31:0] ibMasked = wrData | ({16'h0, ioBase_q[w], 2'h0} & ~byteMask);
        wire logic [31:0] ilMasked = wrData | ({16'h0, ioLimit_q[w], 2'h0} & ~byteMask);
        always_ff @(posedge ref_clk or negedge rstn)
        begin
            if (!rstn)
            begin
                memBase_q[w] <= '0;
                memLimit_q[w] <= '0;
                ioBase_q[w] <= '0;
                ioLimit_q[w] <= '0;
            end
            else if (wrEn)
            begin
                if (wordAddr == MemBaseOff)
                    memBase_q[w] <= mbMasked[31:12];
                if (wordAddr == MemLimitOff)
                    memLimit_q[w] <= mlMasked[31:12];
                if (wordAddr == IoBaseOff)
                    ioBase_q[w] <= ibMasked[15:2];
                if (wordAddr == IoLimitOff)
                    ioLimit_q[w] <= ilMasked[15:2];
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire logic [1:0] ioBaseType = generalControl[cb_window_pkg::IoBaseSelBit]
        ? cb_window_pkg::IoTypeThirtyTwo : cb_window_pkg::IoTypeSixteen;
    wire logic [1:0] ioLimitType = generalControl[cb_window_pkg::IoLimitSelBit]
        ? cb_window_pkg::IoTypeThirtyTwo : cb_window_pkg::IoTypeSixteen;
    wire logic [7:0] pinValue = cb_window_pkg::PinIntA;
    wire logic [31:0] latencyWord = {8'(latency_q), 24'h0};
    wire logic [31:0] irqWord = {16'h0, pinValue, irqLine_q};
    wire logic [31:0] rdMux =
        (wordAddr == latencyWordAddr) ? latencyWord :
        (wordAddr == cb_window_pkg::MemBase0Offset) ? {memBase_q[0], 12'h0} :
        (wordAddr == cb_window_pkg::MemLimit0Offset) ? {memLimit_q[0], 12'h0} :
        (wordAddr == cb_window_pkg::MemBase1Offset) ? {memBase_q[1], 12'h0} :
        (wordAddr == cb_window_pkg::MemLimit1Offset) ? {memLimit_q[1], 12'h0} :
        (wordAddr == cb_window_pkg::IoBase0Offset) ? {16'h0, ioBase_q[0], ioBaseType} :
        (wordAddr == cb_window_pkg::IoLimit0Offset) ? {16'h0, ioLimit_q[0], ioLimitType} :
        (wordAddr == cb_window_pkg::IoBase1Offset) ? {16'h0, ioBase_q[1], ioBaseType} :
        (wordAddr == cb_window_pkg::IoLimit1Offset) ? {16'h0, ioLimit_q[1], ioLimitType} :
        (wordAddr == cb_window_pkg::IrqLineOffset) ? irqWord : 32'h0;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfgRdata <= 32'h0;
            cfgRvalid <= 1'b0;
        end
        else
        begin
            cfgRvalid <= cfgReq.rd;
            if (cfgReq.rd)
                cfgRdata <= rdMux;
        end
    end

    // ----------------------------------------
    // Window decode, host and card side share the same pairs
    // ----------------------------------------
    logic [1:0] memEn;
    logic [1:0] ioEn;
    logic [31:0] memLo [2];
    logic [31:0] memHi [2];
    logic [31:0] ioLo [2];
    logic [31:0] ioHi [2];
    for (genvar w = 0; w < 2; w++)
    begin : gDec
        assign memEn[w] = (memBase_q[w] != '0) || (memLimit_q[w] != '0);
        assign ioEn[w] = (ioBase_q[w] != '0) || (ioLimit_q[w] != '0);
        assign memLo[w] = {memBase_q[w], 12'h0};
        assign memHi[w] = {memLimit_q[w], 12'h0} | cb_window_pkg::MemLimitFill;
        assign ioLo[w] = {16'h0, ioBase_q[w], 2'h0};
        assign ioHi[w] = {16'h0, ioLimit_q[w], 2'h0} | cb_window_pkg::IoLimitFill;
    end

    // Prefetch bits come from bridge control, which resets them to 1
    wire logic [1:0] prefetch = {window1Prefetchable, window0Prefetchable};

    function automatic cb_window_pkg::decode_rsp_type decodeOne(
        input cb_window_pkg::decode_req_type req,
        input logic [1:0] mEn,
        input logic [1:0] iEn,
        input logic [31:0] mLo0, input logic [31:0] mHi0,
        input logic [31:0] mLo1, input logic [31:0] mHi1,
        input logic [31:0] iLo0, input logic [31:0] iHi0,
        input logic [31:0] iLo1, input logic [31:0] iHi1,
        input logic [1:0] pf
    );
        cb_window_pkg::decode_rsp_type rsp;
        logic h0;
        logic h1;
        if (req.isIo)
        begin
            h0 = iEn[0] && req.addr >= iLo0 && req.addr <= iHi0;
            h1 = iEn[1] && req.addr >= iLo1 && req.addr <= iHi1;
        end
        else
        begin
            h0 = mEn[0] && req.addr >= mLo0 && req.addr <= mHi0;
            h1 = mEn[1] && req.addr >= mLo1 && req.addr <= mHi1;
        end
        rsp.hit = h0 || h1;
        rsp.window1 = !h0 && h1;
        rsp.prefetchable = !req.isIo && (h0 ? pf[0] : (h1 && pf[1]));
        return rsp;
    endfunction : decodeOne

    // Host side: forward to the card when a window claims the address
    assign hostRsp = decodeOne(hostReq, memEn, ioEn, memLo[0], memHi[0], memLo[1],
        memHi[1], ioLo[0], ioHi[0], ioLo[1], ioHi[1], prefetch);
    // Card side: a hit stays on the card, a miss goes up to the host
    assign cardRsp = decodeOne(cardReq, memEn, ioEn, memLo[0], memHi[0], memLo[1],
        memHi[1], ioLo[0], ioHi[0], ioLo[1], ioHi[1], prefetch);

    // ----------------------------------------
    // Interrupt joining
    // ----------------------------------------
    wire logic joinAllInterrupts = systemControl[cb_window_pkg::JoinAllBit];
    wire logic joinSecondToFirstInterrupt = systemControl[cb_window_pkg::JoinSecondBit];
    wire logic anyInt = |intIn;
    assign intOut = joinAllInterrupts ? {4{anyInt}} :
        joinSecondToFirstInterrupt ? {intIn[3:2], 1'b0, intIn[0] | intIn[1]} :
        intIn;
    assign secondFuncPin = joinAllInterrupts ? cb_window_pkg::PinIntA
        : cb_window_pkg::PinIntC;

    // ----------------------------------------
    // Card clock sampling and latency counter
    // ----------------------------------------
    // Three stages; the first feeds only the second
    logic [2:0] cclkSync_q;
    logic cclkLevel_q;
    // A level counts only once the last two stages agree
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cclkSync_q <= 3'h0;
            cclkLevel_q <= 1'b0;
        end
        else
        begin
            cclkSync_q <= {cclkSync_q[1:0], cclkPin};
            if (cclkSync_q[1] == cclkSync_q[2])
                cclkLevel_q <= cclkSync_q[2];
        end
    end
    wire logic cclkRise = cclkSync_q[1] && cclkSync_q[2] && !cclkLevel_q;

    logic [LatencyWidth-1:0] latCount_q;
    logic latRun_q;
    logic expired_q;
    wire logic countDone = latRun_q && cclkRise && (latCount_q <= LatencyWidth'(1));
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            latCount_q <= '0;
            latRun_q <= 1'b0;
            expired_q <= 1'b0;
        end
        else if (frameStart)
        begin
            latCount_q <= latency_q;
            latRun_q <= 1'b1;
            expired_q <= (latency_q == '0);
        end
        else if (!transactionActive)
        begin
            latRun_q <= 1'b0;
            expired_q <= 1'b0;
        end
        else if (countDone)
        begin
            latCount_q <= '0;
            latRun_q <= 1'b0;
            expired_q <= 1'b1;
        end
        else if (latRun_q && cclkRise)
            latCount_q <= latCount_q - LatencyWidth'(1);
    end

    // Zero latency expires at once; software should keep it at 20h or more
    assign latencyExpired = expired_q;
    assign terminateAfterPhase = expired_q && transactionActive && dataPhaseDone;

endmodule : cardbus_window_decode_regs

// ==== test/cb_window_asserts.sv ====
// Checker: port-level properties of the window decode block
`timescale 1ns/1ns
module cb_window_asserts (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire cb_window_pkg::cfg_req_type cfgReq,
    input wire logic [31:0] cfgRdata,
    input wire logic cfgRvalid,
    input wire logic [15:0] generalControl,
    input wire logic [31:0] systemControl,
    input wire logic dataPhaseDone,
    input wire logic transactionActive,
    input wire logic latencyExpired,
    input wire logic terminateAfterPhase,
    input wire logic [3:0] intIn,
    input wire logic [3:0] intOut,
    input wire logic [7:0] secondFuncPin
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Read request shapes
    // ----------------------------------------
    sequence memRead;
        cfgReq.rd && cfgReq.addr[7:2] inside {[6'h07:6'h0a]};
    endsequence
    sequence ioBaseRead;
        cfgReq.rd && cfgReq.addr[7:2] inside {6'h0b, 6'h0d};
    endsequence
    sequence ioLimitRead;
        cfgReq.rd && cfgReq.addr[7:2] inside {6'h0c, 6'h0e};
    endsequence
    cfg_reply_a: assert property (cfgReq.rd |=> cfgRvalid) else $error("no read reply");
    mem_low_zero_a: assert property (memRead |=> cfgRdata[11:0] == 12'h000)
        else $error("memory low bits not zero");
    io_upper_zero_a: assert property (
        ioBaseRead or ioLimitRead |=> cfgRdata[31:16] == 16'h0)
        else $error("io upper bits not zero");
    io_base_type_a: assert property (
        ioBaseRead |=> cfgRdata[1:0] == {1'b0, $past(generalControl[11])})
        else $error("io base type bits wrong");
    io_limit_type_a: assert property (
        ioLimitRead |=> cfgRdata[1:0] == {1'b0, $past(generalControl[12])})
        else $error("io limit type bits wrong");
    pin_value_a: assert property (
        cfgReq.rd && cfgReq.addr[7:2] == 6'h0f |=> cfgRdata[15:8] == 8'h01)
        else $error("pin register wrong");
    second_pin_a: assert property (secondFuncPin == (systemControl[28] ? 8'h01 : 8'h03))
        else $error("second pin wrong");
    tie_all_a: assert property (systemControl[28] |-> intOut == {4{|intIn}})
        else $error("join all wrong");
    tie_second_a: assert property (!systemControl[28] && systemControl[29] |->
        intOut == {intIn[3:2], 1'b0, intIn[1] | intIn[0]}) else $error("join second wrong");
    untied_a: assert property (systemControl[29:28] == 2'h0 |-> intOut == intIn)
        else $error("untied interrupts altered");
    expired_hold_a: assert property (latencyExpired && transactionActive |=> latencyExpired)
        else $error("expiry dropped early");
    terminate_cause_a: assert property (terminateAfterPhase |-> latencyExpired && dataPhaseDone)
        else $error("terminate without cause");
endmodule : cb_window_asserts

// ==== test/card_clock_model.sv ====
// Partner model: card clock source that stands still outside own frames
`timescale 1ns/1ns
module card_clock_model #(
    parameter int HalfPeriod = 40
) (
    input wire logic run,
    output logic cclkPin
);
    // Odd start offset keeps it out of phase with the system clock
    initial
    begin
        cclkPin = 1'b0;
        #3;
        forever
        begin
            #HalfPeriod;
            cclkPin = run ? ~cclkPin : 1'b0;
        end
    end
endmodule : card_clock_model

// ==== test/tb.sv ====
// Testbench: registers, window decode, interrupt joining and latency timer
`timescale 1ns/1ns
module tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    cb_window_pkg::cfg_req_type cfgReq = '0;
    logic [31:0] cfgRdata;
    logic cfgRvalid;
    logic window0Prefetchable = 1'b1;
    logic window1Prefetchable = 1'b1;
    logic [15:0] generalControl = 16'h0;
    logic [31:0] systemControl = 32'h0;
    cb_window_pkg::decode_req_type hostReq = '0;
    cb_window_pkg::decode_req_type cardReq = '0;
    cb_window_pkg::decode_rsp_type hostRsp;
    cb_window_pkg::decode_rsp_type cardRsp;
    logic cclkPin;
    logic cardRun = 1'b0;
    logic frameStart = 1'b0;
    logic dataPhaseDone = 1'b0;
    logic transactionActive = 1'b0;
    logic latencyExpired;
    logic terminateAfterPhase;
    logic [3:0] intIn = 4'h0;
    logic [3:0] intOut;
    logic [7:0] secondFuncPin;
    int mismatches = 0;
    int num_checks = 0;
    logic [31:0] winLo [4] = '{default: 32'h0};
    logic [31:0] winHi [4] = '{default: 32'h0};
    always #4 ref_clk = ~ref_clk;
    cardbus_window_decode_regs i_dut (.ref_clk(ref_clk), .rstn(rstn), .cfgReq(cfgReq),
        .cfgRdata(cfgRdata), .cfgRvalid(cfgRvalid), .window0Prefetchable(window0Prefetchable),
        .window1Prefetchable(window1Prefetchable), .generalControl(generalControl),
        .systemControl(systemControl), .hostReq(hostReq), .hostRsp(hostRsp), .cardReq(cardReq),
        .cardRsp(cardRsp), .cclkPin(cclkPin), .frameStart(frameStart),
        .dataPhaseDone(dataPhaseDone), .transactionActive(transactionActive),
        .latencyExpired(latencyExpired), .terminateAfterPhase(terminateAfterPhase),
        .intIn(intIn), .intOut(intOut), .secondFuncPin(secondFuncPin));
    card_clock_model i_card (.run(cardRun), .cclkPin(cclkPin));
    // ----------------------------------------
    // Shared tasks and reference functions
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge ref_clk);
        cfgReq <= '{wr: 1'b1, rd: 1'b0, addr: a, byteEn: be, wdata: d};
        @(posedge ref_clk);
        cfgReq.wr <= 1'b0;
    endtask : cfg_write
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        cfgReq <= '{wr: 1'b0, rd: 1'b1, addr: a, byteEn: 4'hf, wdata: 32'h0};
        @(posedge ref_clk);
        cfgReq.rd <= 1'b0;
        #1;
        check("read valid", {31'h0, cfgRvalid}, 32'h1);
        d = cfgRdata;
    endtask : cfg_read
    function automatic logic [2:0] decode(input logic isIo, input logic [31:0] a);
        logic [31:0] top;
        int j;
        for (int i = 0; i < 2; i++)
        begin
            j = isIo ? i + 2 : i;
            top = winHi[j] | (isIo ? cb_window_pkg::IoLimitFill : cb_window_pkg::MemLimitFill);
            if ((winLo[j] != 0 || winHi[j] != 0) && a >= winLo[j] && a <= top)
                return {1'b1, i[0], i == 0 ? window0Prefetchable : window1Prefetchable};
        end
        return 3'b000;
    endfunction : decode
    // Prefetch type is only defined for memory hits, window only on a hit
    task automatic probe(input logic isIo, input logic [31:0] a);
        logic [2:0] e;
        logic [2:0] m;
        @(posedge ref_clk);
        hostReq <= '{isIo: isIo, addr: a};
        cardReq <= '{isIo: isIo, addr: a};
        window0Prefetchable <= 1'($urandom);
        window1Prefetchable <= 1'($urandom);
        #1;
        e = decode(isIo, a);
        m = !e[2] ? 3'b100 : (isIo ? 3'b110 : 3'b111);
        check("host decode", {29'h0, hostRsp & m}, {29'h0, e & m});
        check("card decode", {29'h0, cardRsp & m}, {29'h0, e & m});
    endtask : probe
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] mask;
        logic [7:0] off;
        int n;
        void'($urandom(32'hb5a1));
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        cfg_read(8'h18, d);
        check("latency reset", {24'h0, d[31:24]}, 32'h0);
        cfg_read(8'h3c, d);
        check("line and pin reset", {16'h0, d[15:0]}, 32'h01ff);
        cfg_read(8'h00, d);
        check("unmapped read", d, 32'h0);
        probe(1'b0, 32'h0);
        probe(1'b1, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            off = 8'h1c + 8'(8 * i);
            mask = i < 2 ? cb_window_pkg::MemWriteMask : cb_window_pkg::IoWriteMask;
            generalControl <= 16'($urandom);
            lo = $urandom;
            hi = lo + ($urandom & (i < 2 ? 32'h0003ffff : 32'h00000fff));
            winLo[i] = lo & mask;
            winHi[i] = hi & mask;
            cfg_write(off, 4'hf, lo);
            cfg_write(off + 8'h4, 4'hf, hi);
            cfg_read(off, d);
            check("window base", d, winLo[i] | (i < 2 ? 32'h0 : 32'(generalControl[11])));
            cfg_read(off + 8'h4, d);
            check("window limit", d, winHi[i] | (i < 2 ? 32'h0 : 32'(generalControl[12])));
        end
        generalControl <= 16'h0;
        for (int k = 0; k < 24; k++)
        begin
            lo = winHi[k % 4] | (k % 4 < 2 ? 32'h00000fff : 32'h00000003);
            case (k / 4)
                0: d = winLo[k % 4];
                1: d = winLo[k % 4] - 32'h1;
                2: d = lo;
                3: d = lo + 32'h1;
                default: d = k % 4 < 2 ? $urandom : ($urandom & 32'h0000ffff);
            endcase
            probe(k % 4 >= 2, d);
        end
        for (int k = 0; k < 8; k++)
        begin
            @(posedge ref_clk);
            systemControl <= ($urandom & 32'hcfffffff) | (32'(k % 4) << 28);
            intIn <= 4'($urandom);
            #1;
            d = systemControl[28] ? {28'h0, {4{|intIn}}} : systemControl[29]
                ? {28'h0, intIn[3:2], 1'b0, intIn[1] | intIn[0]} : {28'h0, intIn};
            check("joined ints", {28'h0, intOut}, d);
            check("second pin", {24'h0, secondFuncPin}, systemControl[28] ? 32'h1 : 32'h3);
        end
        lo = $urandom;
        cfg_write(8'h3c, 4'h3, lo);
        cfg_read(8'h3c, d);
        check("line and pin", {16'h0, d[15:0]}, {16'h0, 8'h01, lo[7:0]});
        // Software keeps the latency at or above 20h
        cfg_write(8'h18, 4'h8, {8'h20, 24'h0});
        cfg_read(8'h18, d);
        check("latency value", {24'h0, d[31:24]}, 32'h20);
        @(posedge ref_clk);
        frameStart <= 1'b1;
        transactionActive <= 1'b1;
        @(posedge ref_clk);
        frameStart <= 1'b0;
        repeat (20) @(posedge ref_clk);
        #1;
        check("no expiry without card clock", {31'h0, latencyExpired}, 32'h0);
        cardRun <= 1'b1;
        n = 0;
        while (latencyExpired !== 1'b1 && n < 600)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("expiry window", 32'(n >= 300 && n <= 335), 32'h1);
        check("no early terminate", {31'h0, terminateAfterPhase}, 32'h0);
        @(posedge ref_clk);
        dataPhaseDone <= 1'b1;
        #1;
        check("terminate", {31'h0, terminateAfterPhase}, 32'h1);
        @(posedge ref_clk);
        dataPhaseDone <= 1'b0;
        transactionActive <= 1'b0;
        cardRun <= 1'b0;
        repeat (3) @(posedge ref_clk);
        results();
    end
    initial
    begin
        #200000;
        mismatches++;
        results();
    end
endmodule : tb
bind cardbus_window_decode_regs cb_window_asserts i_asserts (.ref_clk(ref_clk), .rstn(rstn),
    .cfgReq(cfgReq), .cfgRdata(cfgRdata), .cfgRvalid(cfgRvalid),
    .generalControl(generalControl), .systemControl(systemControl),
    .dataPhaseDone(dataPhaseDone), .transactionActive(transactionActive),
    .latencyExpired(latencyExpired), .terminateAfterPhase(terminateAfterPhase),
    .intIn(intIn), .intOut(intOut), .secondFuncPin(secondFuncPin));
